// >>> dv/qmrsh_host_model.sv
// Host serial controller model: frames opcodes, addresses and reads on the pins
`timescale 1ns/1ps
module qmrsh_host_model #(
   parameter int HALF = 4  // Serial clock half period in system clocks
) (
   input wire logic clk_i,                       // System clock
   input wire qmrsh_pkg::qmrsh_pin_out_t dev_i,  // Device IO outputs
   output qmrsh_pkg::qmrsh_pin_in_t pin_o        // Chip select, serial clock, IO
);
   initial pin_o = 6'h20;

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Drives one unit on IO and clocks it in on the rising edge
   task automatic unit_tx(input logic [3:0] v);
      pin_o.sclk <= 1'b0;
      pin_o.io <= v;
      tick(HALF);
      pin_o.sclk <= 1'b1;
      tick(HALF);
   endtask

   task automatic frame(input bit q, input logic [7:0] op, input bit rd, input logic [23:0] a,
      input int n, output logic [7:0] d [$]);
      logic [31:0] sh;
      logic [7:0] b;
      int w;
      d = {};
      w = q ? 4 : 1;
      sh = {op, a};
      @(posedge clk_i);
      pin_o.cs_n <= 1'b0;
      tick(HALF);
      for (int i = 0; i < (rd ? 32 : 8); i += w) begin
         unit_tx(q ? sh[31 - i -: 4] : {~pin_o.io[3:1], sh[31 - i]});
      end
      if (rd) begin
         repeat (8) unit_tx(~pin_o.io);
      end
      for (int k = 0; k < n; k++) begin
         b = 8'h00;
         repeat (8 / w) begin
            pin_o.sclk <= 1'b0;
            pin_o.io <= ~pin_o.io;  // Released lines toggle
            tick(HALF);
            b = q ? {b[3:0], dev_i.io} : {b[6:0], dev_i.io[1]};
            pin_o.sclk <= 1'b1;
            tick(HALF);
         end
         d.push_back(b);
      end
      pin_o.sclk <= 1'b0;
      tick(HALF);
      pin_o.cs_n <= 1'b1;
      tick(2 * HALF);
   endtask
endmodule  // qmrsh_host_model

// >>> dv/qmrsh_props.sv
// Checker for the command-mode, reset-pair and parameter-header logic
`timescale 1ns/1ps
module qmrsh_props #(
   parameter int RST_CYCLES = 6000  // Recovery length in clocks
) (
   input wire logic clk_sys_i,                       // System clock
   input wire logic rst_i,                           // Async reset
   input wire qmrsh_pkg::qmrsh_pin_in_t pin_i,       // Host pins
   input wire qmrsh_pkg::qmrsh_pin_out_t pin_o,      // Device IO
   input wire logic quad_enable_bit_i,               // Quad enable
   input wire qmrsh_pkg::qmrsh_vol_upd_t vol_upd_i,  // Setting updates
   input wire qmrsh_pkg::qmrsh_vol_t vol_o,          // Settings
   input wire logic four_wire_command_mode_o,        // Mode
   input wire logic abort_o,                         // Abort pulse
   input wire logic recovering_o,                    // Recovery
   input wire logic reset_armed_o,                   // Armed
   input wire logic cmd_valid_o,                     // Foreign opcode pulse
   input wire logic [7:0] cmd_opcode_o               // Foreign opcode
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   int rc_r;

   // Counts cycles spent in recovery
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) rc_r <= 0;
      else rc_r <= recovering_o ? rc_r + 1 : 0;
   end

   AST_ABORT_PULSE: assert property (abort_o |=> !abort_o && recovering_o)
      else $error("abort not a single pulse into recovery");
   AST_ABORT_CLEAR: assert property (abort_o |-> ##[0:2] (vol_o == '0 &&
      !four_wire_command_mode_o && !reset_armed_o)) else $error("reset left settings");
   AST_ABORT_AT_CS: assert property (abort_o || $rose(reset_armed_o) |->
      pin_i.cs_n && $past(pin_i.cs_n, 2)) else $error("reset acted inside a frame");
   AST_RECOV_QUIET: assert property (recovering_o && $past(recovering_o, 3) |->
      !abort_o && !cmd_valid_o && $stable(four_wire_command_mode_o))
      else $error("command accepted in recovery");
   AST_RECOV_LEN: assert property ($fell(recovering_o) |->
      rc_r >= RST_CYCLES - 1 && rc_r <= RST_CYCLES + 1) else $error("recovery length wrong");
   AST_QE_GATE: assert property ($rose(four_wire_command_mode_o) |-> quad_enable_bit_i)
      else $error("four-wire mode without quad enable");
   AST_MODE_AT_CS: assert property ($changed(four_wire_command_mode_o) |->
      pin_i.cs_n && $past(pin_i.cs_n, 2)) else $error("mode changed inside a frame");
   AST_MODE_KEEPS: assert property ($changed(four_wire_command_mode_o) && !abort_o &&
      !$past(abort_o) && !$past(abort_o, 2) && $past(vol_upd_i) == '0 |->
      $stable({vol_o.write_latch_flag, vol_o.suspend_flag, vol_o.wrap_setting_bits}))
      else $error("mode switch changed settings");
   AST_OE_WIDTH: assert property (pin_o.oe != '0 |-> !$past(pin_i.cs_n, 5) &&
      pin_o.oe == (four_wire_command_mode_o ? 4'hF : 4'h2)) else $error("bad output enable");
   AST_OE_HOLD: assert property (pin_o.oe != '0 && !pin_i.cs_n && !$past(pin_i.cs_n) |=>
      pin_o.oe != '0) else $error("output enable dropped inside a read");
   AST_CMD_FOREIGN: assert property (cmd_valid_o |->
      !(cmd_opcode_o inside {8'h38, 8'hFF, 8'h66, 8'h99, 8'h5A}) ##1 !cmd_valid_o)
      else $error("local opcode passed on");
endmodule  // qmrsh_props

bind qmrsh_top qmrsh_props #(.RST_CYCLES(RST_CYCLES)) u_props (
   .clk_sys_i(clk_sys_i),
   .rst_i(rst_i),
   .pin_i(pin_i),
   .pin_o(pin_o),
   .quad_enable_bit_i(quad_enable_bit_i),
   .vol_upd_i(vol_upd_i),
   .vol_o(vol_o),
   .four_wire_command_mode_o(four_wire_command_mode_o),
   .abort_o(abort_o),
   .recovering_o(recovering_o),
   .reset_armed_o(reset_armed_o),
   .cmd_valid_o(cmd_valid_o),
   .cmd_opcode_o(cmd_opcode_o)
);

// >>> dv/qmrsh_top_tb_top.sv
// Self-checking bench for the command-mode, reset-pair and parameter-header logic
`timescale 1ns/1ps
module qmrsh_top_tb_top;
   localparam int RCYC = 200;
   localparam logic [7:0] MK = 8'h3C;  // Arbitrary maker code
   localparam logic [28:0] VOL = {8'h3C, 1'b1, 1'b1, 8'hAB, 8'h5C, 3'h5};
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic quad_enable_bit_i = 1'b0;
   qmrsh_pkg::qmrsh_vol_upd_t vol_upd_i = '0;
   qmrsh_pkg::qmrsh_pin_in_t pin_i;
   qmrsh_pkg::qmrsh_pin_out_t pin_o;
   qmrsh_pkg::qmrsh_vol_t vol_o;
   logic mode, abort, recov, armed, cmd_v;
   logic [7:0] cmd_op;
   logic [7:0] rd [$];
   logic [7:0] hdr [26] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF, 8'h00,
      8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, MK, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00,
      8'h00, 8'hFF, 8'hFF, 8'hFF};
   int num_errors = 0;
   int checks = 0;
   int n_abort = 0;
   int n_cmd = 0;

   always #2.5 clk_sys_i = ~clk_sys_i;

   // Counts the one-cycle pulses
   always @(posedge clk_sys_i) begin
      if (abort === 1'b1) n_abort++;
      if (cmd_v === 1'b1) n_cmd++;
   end

   qmrsh_top #(.RST_CYCLES(RCYC), .MAKER_ID(MK)) dut (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .pin_i(pin_i),
      .pin_o(pin_o),
      .quad_enable_bit_i(quad_enable_bit_i),
      .vol_upd_i(vol_upd_i),
      .vol_o(vol_o),
      .four_wire_command_mode_o(mode),
      .abort_o(abort),
      .recovering_o(recov),
      .reset_armed_o(armed),
      .cmd_valid_o(cmd_v),
      .cmd_opcode_o(cmd_op)
   );

   qmrsh_host_model host (.clk_i(clk_sys_i), .dev_i(pin_o), .pin_o(pin_i));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic op(input bit q, input logic [7:0] o);
      host.frame(q, o, 1'b0, 24'h000000, 0, rd);
   endtask

   task automatic load();
      @(posedge clk_sys_i);
      vol_upd_i <= {1'b1, 8'h3C, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 8'hAB, 1'b1, 8'h5C, 1'b1, 3'h5};
      @(posedge clk_sys_i);
      vol_upd_i <= '0;
      repeat (2) @(posedge clk_sys_i);
      chk(32'(vol_o), 32'(VOL));
   endtask

   task automatic print_verdict();
      $display("Counts: %0d checks, %0d errors", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      int w;
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      chk(32'(vol_o), 32'h0);
      load();
      op(1'b0, 8'h38);
      chk(32'(mode), 32'h0);
      quad_enable_bit_i <= 1'b1;
      op(1'b0, 8'h38);
      chk(32'(mode), 32'h1);
      chk(32'(vol_o), 32'(VOL));
      host.frame(1'b1, 8'h5A, 1'b1, 24'h000000, 26, rd);
      foreach (hdr[k]) chk(32'(rd[k]), 32'(hdr[k]));
      $display("Test four-wire header read done");
      op(1'b1, 8'hFF);
      chk(32'(mode), 32'h0);
      chk(32'(vol_o), 32'(VOL));
      host.frame(1'b0, 8'h5A, 1'b1, 24'h00000A, 4, rd);
      for (int k = 0; k < 4; k++) chk(32'(rd[k]), 32'(hdr[k + 10]));
      op(1'b0, 8'h06);
      chk(32'(cmd_op), 32'h06);
      chk(32'(n_cmd), 32'h1);
      $display("Test single-wire read and mode exit done");
      op(1'b0, 8'h99);
      chk(32'(vol_o), 32'(VOL));
      op(1'b0, 8'h66);
      chk(32'(armed), 32'h1);
      host.frame(1'b0, 8'h66, 1'b1, 24'h000000, 0, rd);
      chk(32'(armed), 32'h0);
      op(1'b0, 8'h66);
      op(1'b0, 8'h06);
      chk(32'(armed), 32'h0);
      chk(32'(n_cmd), 32'h2);
      op(1'b0, 8'h99);
      chk(32'(vol_o), 32'(VOL));
      $display("Test unarmed reset done");
      for (int m = 0; m < 2; m++) begin
         if (m == 1) op(1'b0, 8'h38);
         chk(32'(vol_o.suspend_flag), 32'h1);
         op(m == 1, 8'h66);
         op(m == 1, 8'h99);
         chk(32'(recov), 32'h1);
         chk(32'(vol_o), 32'h0);
         chk(32'(mode), 32'h0);
         chk(32'(n_abort), 32'(m + 1));
         op(1'b0, 8'h38);
         chk(32'(mode), 32'h0);
         for (w = 0; w < 400 && recov; w++) @(posedge clk_sys_i);
         if (recov !== 1'b0) begin
            num_errors++;
            print_verdict();
         end
         load();
         $display("Test reset pair in mode %0d done", m);
      end
      print_verdict();
   end
endmodule  // qmrsh_top_tb_top

// >>> verilog/qmrsh_hdr_rom.sv
// Read-only image of the discoverable-parameter header space
`timescale 1ns/1ps
module qmrsh_hdr_rom #(
   parameter logic [7:0] MAKER_ID = qmrsh_pkg::MAKER_ID_DEFAULT  // Arbitrary neutral value
) (
   input wire logic [23:0] addr_i,  // Byte address
   output logic [7:0] data_o        // Byte at that address
);

   // ----------------------------------------------------------------
   // Image, byte 0 in the low bits; fixed bytes cannot be written
   // ----------------------------------------------------------------
   localparam int IMG_W = qmrsh_pkg::HDR_BYTES * 8;

   logic [IMG_W-1:0] image;

   assign image = {
      qmrsh_pkg::HDR_UNUSED,
      qmrsh_pkg::PH2_TABLE_POINTER,
      qmrsh_pkg::PH2_LEN_DW,
      qmrsh_pkg::PH_MAJOR_REV,
      qmrsh_pkg::PH_MINOR_REV,
      MAKER_ID,
      qmrsh_pkg::HDR_UNUSED,
      qmrsh_pkg::PH1_TABLE_POINTER,
      qmrsh_pkg::PH1_LEN_DW,
      qmrsh_pkg::PH_MAJOR_REV,
      qmrsh_pkg::PH_MINOR_REV,
      qmrsh_pkg::PH1_ID,
      qmrsh_pkg::HDR_UNUSED,
      qmrsh_pkg::HDR_COUNT,
      qmrsh_pkg::HDR_MAJOR_REV,
      qmrsh_pkg::HDR_MINOR_REV,
      qmrsh_pkg::HDR_SIGNATURE
   };

   // Table contents beyond the header are not held here and read as fill
   always_comb begin
      if (addr_i < 24'(qmrsh_pkg::HDR_BYTES)) begin
         data_o = image[addr_i[4:0]*8 +: 8];
      end else begin
         data_o = qmrsh_pkg::FILL_BYTE;
      end
   end

endmodule // qmrsh_hdr_rom

// >>> verilog/qmrsh_pkg.sv
// Shared constants and types for the command-mode, reset-pair and parameter-header logic
package qmrsh_pkg;

   // ----------------------------------------------------------------
   // Opcodes handled locally
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_ENTER_4W = 8'h38;
   localparam logic [7:0] OP_EXIT_4W = 8'hFF;
   localparam logic [7:0] OP_RST_EN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   localparam logic [7:0] OP_PARAM_RD = 8'h5A;

   // ----------------------------------------------------------------
   // Frame field lengths, in bits or serial clocks
   // ----------------------------------------------------------------
   localparam logic [4:0] OPC_BITS = 5'h08;
   localparam logic [4:0] ADDR_BITS = 5'h18;
   localparam logic [4:0] DUMMY_CLKS = 5'h08;
   localparam logic [4:0] STEP_1W = 5'h01;
   localparam logic [4:0] STEP_4W = 5'h04;
   localparam logic [2:0] LAST_BIT_1W = 3'h7;
   localparam logic [2:0] LAST_NIB_4W = 3'h1;

   // ----------------------------------------------------------------
   // Reset recovery time
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int T_RST_NS = 30000;
   localparam int RST_CYCLES = (T_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // ----------------------------------------------------------------
   // Parameter header image
   // ----------------------------------------------------------------
   localparam logic [31:0] HDR_SIGNATURE = 32'h50444653;
   localparam logic [7:0] HDR_MINOR_REV = 8'h00;
   localparam logic [7:0] HDR_MAJOR_REV = 8'h01;
   localparam logic [7:0] HDR_COUNT = 8'h01;
   localparam logic [7:0] HDR_UNUSED = 8'hFF;
   localparam logic [7:0] PH1_ID = 8'h00;
   localparam logic [7:0] PH_MINOR_REV = 8'h00;
   localparam logic [7:0] PH_MAJOR_REV = 8'h01;
   localparam logic [7:0] PH1_LEN_DW = 8'h09;
   localparam logic [23:0] PH1_TABLE_POINTER = 24'h000030;
   localparam logic [7:0] PH2_LEN_DW = 8'h03;
   localparam logic [23:0] PH2_TABLE_POINTER = 24'h000060;
   localparam logic [7:0] MAKER_ID_DEFAULT = 8'hA5;  // Arbitrary neutral value
   localparam int HDR_BYTES = 24;
   localparam logic [7:0] FILL_BYTE = 8'hFF;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic [3:0] io;
   } qmrsh_pin_in_t;

   typedef struct packed {
      logic [3:0] io;
      logic [3:0] oe;
   } qmrsh_pin_out_t;

   typedef struct packed {
      logic [7:0] vstat;
      logic write_latch_flag;
      logic suspend_flag;
      logic [7:0] read_param_field;
      logic [7:0] continuous_read_bits;
      logic [2:0] wrap_setting_bits;
   } qmrsh_vol_t;

   typedef struct packed {
      logic vstat_ld;
      logic [7:0] vstat;
      logic wlf_set;
      logic wlf_clr;
      logic susp_set;
      logic susp_clr;
      logic rpf_ld;
      logic [7:0] rpf;
      logic crb_ld;
      logic [7:0] crb;
      logic wsb_ld;
      logic [2:0] wsb;
   } qmrsh_vol_upd_t;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_OPC = 7'h02,
      ST_ADDR = 7'h04,
      ST_DUMMY = 7'h08,
      ST_DATA = 7'h10,
      ST_SKIP = 7'h20,
      ST_RECOV = 7'h40
   } qmrsh_fsm_t;

endpackage

// >>> verilog/qmrsh_top.sv
// Command-mode switch, reset pair and parameter-header reader of a serial flash
// Summary of operation
// - Opcode 38H enters four-wire command mode when quad enable bit is set.
// - With quad enable bit clear, 38H is ignored; mode stays single-wire.
// - Entering four-wire mode keeps write latch, suspend and wrap setting.
// - Opcode FFH returns the device from four-wire to single-wire mode.
// - Leaving four-wire mode with FFH keeps write latch, suspend and wrap setting.
// - Accepted reset aborts internal operations and restores power-on defaults.
// - Accepted reset clears every volatile setting held by this block.
// - Reset-enable and reset opcodes work in both command modes.
// - Every command is refused during the reset recovery time.
// - Opcode 5AH reads the parameter space in both command modes.
// - Bytes 00H-03H give the signature LSB first; 04H gives minor revision.
// - Byte 05H major revision 01H; byte 06H header count 01H.
// - Bytes 07H, 0FH and 17H always read FFH.
// - First header: ID, revisions and length 09H at bytes 08H-0BH.
// - Bytes 0CH-0EH give pointer 000030H, LSB first.
// - Second header: maker ID, revisions and length 03H at bytes 10H-13H.
// - Bytes 14H-16H give pointer 000060H, LSB first.
`timescale 1ns/1ps
module qmrsh_top #(
   parameter int RST_CYCLES = qmrsh_pkg::RST_CYCLES,                // Recovery length in clocks
   parameter logic [7:0] MAKER_ID = qmrsh_pkg::MAKER_ID_DEFAULT     // Arbitrary neutral value
) (
   input wire logic clk_sys_i,                          // System clock, 200 MHz
   input wire logic rst_i,                              // Async reset, active high
   input wire qmrsh_pkg::qmrsh_pin_in_t pin_i,          // Chip select, serial clock, IO in
   output qmrsh_pkg::qmrsh_pin_out_t pin_o,             // IO out and enables
   input wire logic quad_enable_bit_i,                  // Quad enable from status register
   input wire qmrsh_pkg::qmrsh_vol_upd_t vol_upd_i,     // Volatile setting updates
   output qmrsh_pkg::qmrsh_vol_t vol_o,                 // Volatile settings
   output logic four_wire_command_mode_o,               // High in four-wire command mode
   output logic abort_o,                                // Pulse: abort internal operation
   output logic recovering_o,                           // High during reset recovery
   output logic reset_armed_o,                          // Reset-enable frame seen
   output logic cmd_valid_o,                            // Pulse: foreign opcode received
   output logic [7:0] cmd_opcode_o                      // Foreign opcode
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      qmrsh_pkg::qmrsh_pin_in_t sync1;
      qmrsh_pkg::qmrsh_pin_in_t sync2;
      logic sclk_d;
      qmrsh_pkg::qmrsh_fsm_t st;
      logic quad;
      logic armed;
      logic [7:0] pend;
      logic pend_v;
      logic spare;
      logic drv;
      logic [4:0] cnt;
      logic [23:0] sh;
      logic [23:0] addr;
      logic [7:0] dout;
      logic [2:0] oc;
      logic [3:0] io_out;
      logic [23:0] rcnt;
      qmrsh_pkg::qmrsh_vol_t vol;
      logic abort;
      logic cmd_v;
      logic [7:0] cmd;
   } qmrsh_state_t;

   localparam qmrsh_state_t STATE_RST = '{
      sync1: '{cs_n: 1'h1, sclk: 1'h0, io: 4'h0},
      sync2: '{cs_n: 1'h1, sclk: 1'h0, io: 4'h0},
      sclk_d: 1'h0,
      st: qmrsh_pkg::ST_IDLE,
      quad: 1'h0,
      armed: 1'h0,
      pend: 8'h00,
      pend_v: 1'h0,
      spare: 1'h0,
      drv: 1'h0,
      cnt: 5'h00,
      sh: 24'h000000,
      addr: 24'h000000,
      dout: 8'h00,
      oc: 3'h0,
      io_out: 4'h0,
      rcnt: 24'h000000,
      vol: '0,
      abort: 1'h0,
      cmd_v: 1'h0,
      cmd: 8'h00
   };

   qmrsh_state_t s_r;
   qmrsh_state_t s_nxt;
   logic [7:0] rom_q;

   // ----------------------------------------------------------------
   // Header image
   // ----------------------------------------------------------------
   qmrsh_hdr_rom #(
      .MAKER_ID(MAKER_ID)
   ) u_rom (
      .addr_i(s_r.addr),
      .data_o(rom_q)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic cs_hi;
      logic rise;
      logic fall;
      logic [4:0] step;
      logic [4:0] cntv;
      logic [23:0] shv;
      logic last_chunk;
      cs_hi = s_r.sync2.cs_n;
      rise = s_r.sync2.sclk & ~s_r.sclk_d;
      fall = ~s_r.sync2.sclk & s_r.sclk_d;
      step = s_r.quad ? qmrsh_pkg::STEP_4W : qmrsh_pkg::STEP_1W;
      cntv = s_r.cnt + step;
      shv = s_r.quad ? {s_r.sh[19:0], s_r.sync2.io} : {s_r.sh[22:0], s_r.sync2.io[0]};
      last_chunk = s_r.quad ? (s_r.oc == qmrsh_pkg::LAST_NIB_4W)
                            : (s_r.oc == qmrsh_pkg::LAST_BIT_1W);

      s_nxt = s_r;
      s_nxt.sync1 = pin_i;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.sclk_d = s_r.sync2.sclk;
      s_nxt.abort = 1'h0;
      s_nxt.cmd_v = 1'h0;

      // Updates from the rest of the device; sets win over clears
      if (vol_upd_i.vstat_ld) begin
         s_nxt.vol.vstat = vol_upd_i.vstat;
      end
      if (vol_upd_i.wlf_set) begin
         s_nxt.vol.write_latch_flag = 1'h1;
      end else if (vol_upd_i.wlf_clr) begin
         s_nxt.vol.write_latch_flag = 1'h0;
      end
      if (vol_upd_i.susp_set) begin
         s_nxt.vol.suspend_flag = 1'h1;
      end else if (vol_upd_i.susp_clr) begin
         s_nxt.vol.suspend_flag = 1'h0;
      end
      if (vol_upd_i.rpf_ld) begin
         s_nxt.vol.read_param_field = vol_upd_i.rpf;
      end
      if (vol_upd_i.crb_ld) begin
         s_nxt.vol.continuous_read_bits = vol_upd_i.crb;
      end
      if (vol_upd_i.wsb_ld) begin
         s_nxt.vol.wrap_setting_bits = vol_upd_i.wsb;
      end

      unique case (s_r.st)
         qmrsh_pkg::ST_IDLE: begin
            if (!cs_hi) begin
               s_nxt.st = qmrsh_pkg::ST_OPC;
               s_nxt.cnt = 5'h00;
               s_nxt.sh = 24'h000000;
               s_nxt.pend_v = 1'h0;
               s_nxt.spare = 1'h0;
               s_nxt.drv = 1'h0;
            end
         end
         qmrsh_pkg::ST_OPC: begin
            if (cs_hi) begin
               s_nxt.armed = 1'h0;
               s_nxt.st = qmrsh_pkg::ST_IDLE;
            end else if (rise) begin
               s_nxt.sh = shv;
               s_nxt.cnt = cntv;
               if (cntv == qmrsh_pkg::OPC_BITS) begin
                  s_nxt.cnt = 5'h00;
                  s_nxt.st = qmrsh_pkg::ST_SKIP;
                  unique case (shv[7:0])
                     qmrsh_pkg::OP_PARAM_RD: begin
                        s_nxt.st = qmrsh_pkg::ST_ADDR;
                     end
                     qmrsh_pkg::OP_ENTER_4W, qmrsh_pkg::OP_EXIT_4W,
                     qmrsh_pkg::OP_RST_EN, qmrsh_pkg::OP_RST: begin
                        s_nxt.pend = shv[7:0];
                        s_nxt.pend_v = 1'h1;
                     end
                     default: begin
                        s_nxt.cmd_v = 1'h1;
                        s_nxt.cmd = shv[7:0];
                     end
                  endcase
               end
            end
         end
         qmrsh_pkg::ST_ADDR: begin
            if (cs_hi) begin
               s_nxt.armed = 1'h0;
               s_nxt.st = qmrsh_pkg::ST_IDLE;
            end else if (rise) begin
               s_nxt.sh = shv;
               s_nxt.cnt = cntv;
               if (cntv == qmrsh_pkg::ADDR_BITS) begin
                  s_nxt.addr = shv;
                  s_nxt.cnt = 5'h00;
                  s_nxt.st = qmrsh_pkg::ST_DUMMY;
               end
            end
         end
         qmrsh_pkg::ST_DUMMY: begin
            if (cs_hi) begin
               s_nxt.armed = 1'h0;
               s_nxt.st = qmrsh_pkg::ST_IDLE;
            end else if (rise) begin
               s_nxt.cnt = s_r.cnt + qmrsh_pkg::STEP_1W;
               if (s_r.cnt == qmrsh_pkg::DUMMY_CLKS - qmrsh_pkg::STEP_1W) begin
                  s_nxt.dout = rom_q;
                  s_nxt.addr = s_r.addr + 24'h000001;
                  s_nxt.oc = 3'h0;
                  s_nxt.st = qmrsh_pkg::ST_DATA;
               end
            end
         end
         qmrsh_pkg::ST_DATA: begin
            if (cs_hi) begin
               s_nxt.armed = 1'h0;
               s_nxt.st = qmrsh_pkg::ST_IDLE;
            end else if (fall) begin
               // Shift out MSB first; reload from the next address at byte end
               if (s_r.quad) begin
                  s_nxt.io_out = s_r.dout[7:4];
                  s_nxt.dout = {s_r.dout[3:0], 4'h0};
               end else begin
                  s_nxt.io_out = {2'h0, s_r.dout[7], 1'h0};
                  s_nxt.dout = {s_r.dout[6:0], 1'h0};
               end
               s_nxt.oc = s_r.oc + 3'h1;
               s_nxt.drv = 1'h1;
               if (last_chunk) begin
                  s_nxt.dout = rom_q;
                  s_nxt.addr = s_r.addr + 24'h000001;
                  s_nxt.oc = 3'h0;
               end
            end
         end
         qmrsh_pkg::ST_SKIP: begin
            if (rise) begin
               s_nxt.spare = 1'h1;
            end
            if (cs_hi) begin
               s_nxt.st = qmrsh_pkg::ST_IDLE;
               s_nxt.armed = 1'h0;
               if (s_r.pend_v && !s_r.spare) begin
                  unique case (s_r.pend)
                     qmrsh_pkg::OP_RST_EN: begin
                        s_nxt.armed = 1'h1;
                     end
                     qmrsh_pkg::OP_RST: begin
                        if (s_r.armed) begin
                           s_nxt.vol = '0;
                           s_nxt.quad = 1'h0;
                           s_nxt.abort = 1'h1;
                           s_nxt.rcnt = 24'h000000;
                           s_nxt.st = qmrsh_pkg::ST_RECOV;
                        end
                     end
                     qmrsh_pkg::OP_ENTER_4W: begin
                        if (quad_enable_bit_i) begin
                           s_nxt.quad = 1'h1;
                        end
                     end
                     qmrsh_pkg::OP_EXIT_4W: begin
                        s_nxt.quad = 1'h0;
                     end
                     default: begin
                        s_nxt.armed = 1'h0;
                     end
                  endcase
               end
            end
         end
         qmrsh_pkg::ST_RECOV: begin
            s_nxt.rcnt = s_r.rcnt + 24'h000001;
            if (s_r.rcnt == 24'(RST_CYCLES - 1)) begin
               // A frame still open at the end of recovery is discarded
               s_nxt.pend_v = 1'h0;
               s_nxt.spare = 1'h1;
               s_nxt.st = qmrsh_pkg::ST_SKIP;
            end
         end
         default: begin
            s_nxt.st = qmrsh_pkg::ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb begin
      pin_o.io = s_r.io_out;
      pin_o.oe = 4'h0;
      // Driven from the first data fall until chip select rises, byte ends included
      if (s_r.st == qmrsh_pkg::ST_DATA && !s_r.sync2.cs_n && s_r.drv) begin
         pin_o.oe = s_r.quad ? 4'hF : 4'h2;
      end
   end

   assign vol_o = s_r.vol;
   assign four_wire_command_mode_o = s_r.quad;
   assign abort_o = s_r.abort;
   assign recovering_o = (s_r.st == qmrsh_pkg::ST_RECOV);
   assign reset_armed_o = s_r.armed;
   assign cmd_valid_o = s_r.cmd_v;
   assign cmd_opcode_o = s_r.cmd;

endmodule // qmrsh_top
